//--- logic/mfd_defs.svh
// Offsets, field positions, reset values and timing figures of the multifunction block
`ifndef MFD_DEFS_SVH
`define MFD_DEFS_SVH

// ---------------------------------------------------------------
// Sizes and timing
// ---------------------------------------------------------------
`define MFD_PORT_W        8
`define MFD_CNT_W         26
`define MFD_DAC_W         16
`define MFD_CLK_KHZ       40000
`define MFD_PULSE_MAX_KHZ 100
`define MFD_MIN_OVERSAMPLE 4

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define MFD_OFS_CTRL      6'h00
`define MFD_OFS_STATUS    6'h04
`define MFD_OFS_PORT_IN   6'h08
`define MFD_OFS_PORT_OUT  6'h0C
`define MFD_OFS_ALM_PAT   6'h10
`define MFD_OFS_ALM_MASK  6'h14
`define MFD_OFS_COUNT     6'h18
`define MFD_OFS_SCAN_IN   6'h1C
`define MFD_OFS_SCAN_CNT  6'h20
`define MFD_OFS_DAC0      6'h24
`define MFD_OFS_DAC1      6'h28

// ---------------------------------------------------------------
// Control and status fields
// ---------------------------------------------------------------
`define MFD_CTRL_FALL     0
`define MFD_CTRL_CLR      1
`define MFD_CTRL_OE_A     2
`define MFD_CTRL_OE_B     3
`define MFD_CTRL_ALM_MODE 4
`define MFD_CTRL_ALM_EN   5
`define MFD_ST_ALM        0
`define MFD_ST_SCAN_VLD   2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MFD_RST_CTRL      8'h00
`define MFD_RST_OUT       16'hFFFF
`define MFD_RST_MASK      16'hFFFF
`define MFD_RST_DAC       16'h0000

`endif

//--- logic/mfd_pkg.sv
// Types shared by the multifunction block
package mfd_pkg;
	typedef enum logic {BUS_IDLE, BUS_ACK} mfd_bus_st_t;
	typedef enum logic {ALM_MATCH, ALM_CHANGE} mfd_alm_mode_t;
endpackage

//--- logic/mfd_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module mfd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	generate
		if (W < 1) begin : g_chk
			$error("mfd_sync width must be at least one");
		end
	endgenerate

	// First stage is read only by the second stage
	always_comb begin
		next_meta = async_in;
		next_sync = meta;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= next_meta;
			sync_out <= next_sync;
		end
	end
endmodule

//--- logic/mfd_top.sv
// Multifunction digital ports, totalizer and voltage-output codes behind an Avalon-MM slave
//
// Summary of operation
// - Two 8-bit ports can be read live or captured together as one scan reading.
// - A port raises an alarm on a pattern match or a pattern change, scanned or not.
// - An open input reads as one and a grounded input reads as zero.
// - Both ports can be driven together as one 16-bit output word.
// - The totalizer is 26 bits wide and keeps up with pulses up to 100 kHz.
// - The count can be read on request or captured as one scan reading.
// - A control bit picks rising or falling edges for counting.
// - After the maximum count the next counted edge gives zero.
// - The high-active gate enables counting while high.
// - The low-active gate enables counting while low.
// - Counting happens only while both gates enable at once.
// - An unconnected high-active gate counts as enabling; an unconnected low-active gate floats high and stops counting.
// - Each voltage output takes a 16-bit code in 1 mV steps across the full range.
`timescale 1ns/1ps
`include "mfd_defs.svh"
module mfd_top import mfd_pkg::*; #(
	parameter int CNT_W   = `MFD_CNT_W,
	parameter int CLK_KHZ = `MFD_CLK_KHZ
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	// Avalon-MM slave
	input  wire logic [5:0]        avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic      [31:0]       avs_readdata_out,
	output logic                   avs_waitrequest_out,
	// Scan sequencer
	input  wire logic              scan_trig_in,
	output logic                   scan_done_out,
	output logic      [15:0]       scan_port_out,
	output logic      [CNT_W-1:0]  scan_count_out,
	// Digital port pins, two-way
	input  wire logic [7:0]        port_a_in,
	output logic      [7:0]        port_a_out,
	output logic      [7:0]        port_a_oe_out,
	input  wire logic [7:0]        port_b_in,
	output logic      [7:0]        port_b_out,
	output logic      [7:0]        port_b_oe_out,
	// Totalizer pins
	input  wire logic              tot_pulse_in,
	input  wire logic              gate_hi_in,
	input  wire logic              gate_lo_b_in,
	// Alarm and voltage-output codes
	output logic                   alarm_out,
	output logic      [15:0]       dac0_code_out,
	output logic      [15:0]       dac1_code_out
);
	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	generate
		if (CNT_W < 2 || CNT_W > 32) begin : g_chk_w
			$error("mfd_top count width must be 2 to 32");
		end
		// Both pulse phases must last several clocks to be seen
		if (CLK_KHZ / `MFD_PULSE_MAX_KHZ < `MFD_MIN_OVERSAMPLE * 2) begin : g_chk_clk
			$error("mfd_top clock too slow for the pulse rate");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Merge write data into a 16-bit register under byte enables
	function automatic logic [15:0] be_merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	logic [18:0]      pins_s;
	logic [15:0]      port_s;
	logic             pulse_s;
	logic             gate_hi_s;
	logic             gate_lo_b_s;

	// Pins come from outside; none is looked at before two flops
	mfd_sync #(
		.W (19)
	) u_sync (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.async_in ({gate_lo_b_in, gate_hi_in, tot_pulse_in, port_b_in, port_a_in}),
		.sync_out (pins_s)
	);

	// Pull-ups outside make an open pin read one; the raw level is shown
	assign port_s      = pins_s[15:0];
	assign pulse_s     = pins_s[16];
	assign gate_hi_s   = pins_s[17];  // Floats high when open
	assign gate_lo_b_s = pins_s[18];  // Drive it low or ground it to enable

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	mfd_bus_st_t      bus_st;
	mfd_bus_st_t      next_bus_st;
	logic [7:0]       ctrl;
	logic [7:0]       next_ctrl;
	logic [15:0]      out_word;
	logic [15:0]      next_out_word;
	logic [15:0]      alm_pat;
	logic [15:0]      next_alm_pat;
	logic [15:0]      alm_mask;
	logic [15:0]      next_alm_mask;
	logic [15:0]      dac0;
	logic [15:0]      next_dac0;
	logic [15:0]      dac1;
	logic [15:0]      next_dac1;
	logic [31:0]      rdata;
	logic [31:0]      next_rdata;

	logic             req;
	logic             wr_go;
	logic [CNT_W-1:0] count;
	logic             cnt_clr;

	// ---------------------------------------------------------------
	// Bus handshake
	// ---------------------------------------------------------------
	// One wait cycle per access: read data is captured on the first edge,
	// so the whole count comes from a single edge even if a pulse lands
	assign req                 = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & (bus_st == BUS_IDLE);
	assign wr_go               = avs_write_in & (bus_st == BUS_ACK);
	assign avs_readdata_out    = rdata;

	// Count clear is a write-one pulse, never stored
	assign cnt_clr = wr_go & (avs_address_in == `MFD_OFS_CTRL)
		& avs_byteenable_in[0] & avs_writedata_in[`MFD_CTRL_CLR];

	// ---------------------------------------------------------------
	// Totalizer
	// ---------------------------------------------------------------
	mfd_tot #(
		.W (CNT_W)
	) u_tot (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.pulse_in     (pulse_s),
		.gate_hi_in   (gate_hi_s),
		.gate_lo_b_in (gate_lo_b_s),
		.edge_fall_in (ctrl[`MFD_CTRL_FALL]),
		.clear_in     (cnt_clr),
		.count_out    (count)
	);

	// ---------------------------------------------------------------
	// Alarms
	// ---------------------------------------------------------------
	logic [1:0]       alm_st;
	logic [1:0]       next_alm_st;
	logic [1:0]       match_prev;
	logic [1:0]       next_match_prev;
	logic [15:0]      in_prev;
	logic [15:0]      next_in_prev;
	logic [1:0]       alm_ev;
	logic [1:0]       alm_clr;

	// Status bits are write-one-to-clear
	assign alm_clr = (wr_go && avs_address_in == `MFD_OFS_STATUS && avs_byteenable_in[0])
		? avs_writedata_in[`MFD_ST_ALM +: 2] : 2'b00;

	// Watches the live pins whether or not the port is in a scan
	always_comb begin
		next_in_prev    = port_s;
		next_match_prev = match_prev;
		next_alm_st     = alm_st;
		alm_ev          = 2'b00;
		for (int p = 0; p < 2; p++) begin
			logic [7:0]    pin;
			logic [7:0]    msk;
			logic          hit_m;
			logic          hit_c;
			mfd_alm_mode_t mode;
			pin   = port_s[8*p +: 8];
			msk   = alm_mask[8*p +: 8];
			hit_m = ((pin ^ alm_pat[8*p +: 8]) & msk) == 8'h00;
			hit_c = ((pin ^ in_prev[8*p +: 8]) & msk) != 8'h00;
			mode  = mfd_alm_mode_t'(ctrl[`MFD_CTRL_ALM_MODE + 2*p]);
			next_match_prev[p] = hit_m;
			if (ctrl[`MFD_CTRL_ALM_EN + 2*p]) begin
				// A match alarms once on entry; a change alarms on every change
				alm_ev[p] = (mode == ALM_CHANGE) ? hit_c : (hit_m & ~match_prev[p]);
			end
			// A new event wins over a clear in the same cycle
			next_alm_st[p] = alm_ev[p] | (alm_st[p] & ~alm_clr[p]);
		end
	end

	assign alarm_out = |alm_st;

	// ---------------------------------------------------------------
	// Scan capture
	// ---------------------------------------------------------------
	logic             scan_vld;
	logic             next_scan_vld;
	logic             next_scan_done;
	logic [15:0]      next_scan_port;
	logic [CNT_W-1:0] next_scan_count;

	// Ports and count are caught on the same edge as one reading
	always_comb begin
		next_scan_done  = scan_trig_in;
		next_scan_port  = scan_trig_in ? port_s : scan_port_out;
		next_scan_count = scan_trig_in ? count : scan_count_out;
		next_scan_vld   = scan_vld | scan_trig_in;
		if (wr_go && avs_address_in == `MFD_OFS_STATUS && avs_byteenable_in[0]
			&& avs_writedata_in[`MFD_ST_SCAN_VLD] && !scan_trig_in) begin
			next_scan_vld = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Register writes and read mux
	// ---------------------------------------------------------------
	always_comb begin
		next_bus_st   = (req && bus_st == BUS_IDLE) ? BUS_ACK : BUS_IDLE;
		next_ctrl     = ctrl;
		next_out_word = out_word;
		next_alm_pat  = alm_pat;
		next_alm_mask = alm_mask;
		next_dac0     = dac0;
		next_dac1     = dac1;
		next_rdata    = rdata;
		if (wr_go) begin
			case (avs_address_in)
				`MFD_OFS_CTRL: begin
					if (avs_byteenable_in[0]) begin
						next_ctrl = avs_writedata_in[7:0] & ~8'h02;
					end
				end
				`MFD_OFS_PORT_OUT: begin
					// A full-word write drives both ports on one edge
					next_out_word = be_merge16(out_word, avs_writedata_in,
						avs_byteenable_in);
				end
				`MFD_OFS_ALM_PAT: begin
					next_alm_pat = be_merge16(alm_pat, avs_writedata_in, avs_byteenable_in);
				end
				`MFD_OFS_ALM_MASK: begin
					next_alm_mask = be_merge16(alm_mask, avs_writedata_in, avs_byteenable_in);
				end
				`MFD_OFS_DAC0: begin
					next_dac0 = be_merge16(dac0, avs_writedata_in, avs_byteenable_in);
				end
				`MFD_OFS_DAC1: begin
					next_dac1 = be_merge16(dac1, avs_writedata_in, avs_byteenable_in);
				end
				default: begin
					next_ctrl = ctrl;
				end
			endcase
		end
		if (avs_read_in && bus_st == BUS_IDLE) begin
			case (avs_address_in)
				`MFD_OFS_CTRL:     next_rdata = {24'h00_0000, ctrl};
				`MFD_OFS_STATUS:   next_rdata = {29'h0000_0000, scan_vld, alm_st};
				`MFD_OFS_PORT_IN:  next_rdata = {16'h0000, port_s};
				`MFD_OFS_PORT_OUT: next_rdata = {16'h0000, out_word};
				`MFD_OFS_ALM_PAT:  next_rdata = {16'h0000, alm_pat};
				`MFD_OFS_ALM_MASK: next_rdata = {16'h0000, alm_mask};
				`MFD_OFS_COUNT:    next_rdata = 32'(count);
				`MFD_OFS_SCAN_IN:  next_rdata = {16'h0000, scan_port_out};
				`MFD_OFS_SCAN_CNT: next_rdata = 32'(scan_count_out);
				`MFD_OFS_DAC0:     next_rdata = {16'h0000, dac0};
				`MFD_OFS_DAC1:     next_rdata = {16'h0000, dac1};
				default:           next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			bus_st         <= BUS_IDLE;
			ctrl           <= `MFD_RST_CTRL;
			out_word       <= `MFD_RST_OUT;
			alm_pat        <= 16'h0000;
			alm_mask       <= `MFD_RST_MASK;
			dac0           <= `MFD_RST_DAC;
			dac1           <= `MFD_RST_DAC;
			rdata          <= 32'h0000_0000;
			alm_st         <= 2'b00;
			match_prev     <= 2'b00;
			in_prev        <= 16'h0000;
			scan_vld       <= 1'b0;
			scan_done_out  <= 1'b0;
			scan_port_out  <= 16'h0000;
			scan_count_out <= '0;
		end else begin
			bus_st         <= next_bus_st;
			ctrl           <= next_ctrl;
			out_word       <= next_out_word;
			alm_pat        <= next_alm_pat;
			alm_mask       <= next_alm_mask;
			dac0           <= next_dac0;
			dac1           <= next_dac1;
			rdata          <= next_rdata;
			alm_st         <= next_alm_st;
			match_prev     <= next_match_prev;
			in_prev        <= next_in_prev;
			scan_vld       <= next_scan_vld;
			scan_done_out  <= next_scan_done;
			scan_port_out  <= next_scan_port;
			scan_count_out <= next_scan_count;
		end
	end

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	// Outputs drive both levels; a zero bit actively sinks for external switches
	assign port_a_out    = out_word[7:0];
	assign port_b_out    = out_word[15:8];
	assign port_a_oe_out = {8{ctrl[`MFD_CTRL_OE_A]}};
	assign port_b_oe_out = {8{ctrl[`MFD_CTRL_OE_B]}};
	assign dac0_code_out = dac0;  // Two's complement, one LSB per millivolt
	assign dac1_code_out = dac1;
endmodule

//--- logic/mfd_tot.sv
// Gated edge totalizer with wrap-around
`timescale 1ns/1ps
`include "mfd_defs.svh"
module mfd_tot import mfd_pkg::*; #(
	parameter int W = `MFD_CNT_W
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	// Synchronised inputs
	input  wire logic         pulse_in,
	input  wire logic         gate_hi_in,
	input  wire logic         gate_lo_b_in,
	// Control
	input  wire logic         edge_fall_in,
	input  wire logic         clear_in,
	// Count
	output logic      [W-1:0] count_out
);
	logic         prev;
	logic [1:0]   prime;
	logic         hit;
	logic         next_prev;
	logic [1:0]   next_prime;
	logic [W-1:0] next_count;

	generate
		if (W < 2 || W > 32) begin : g_chk
			$error("mfd_tot width must be 2 to 32");
		end
	endgenerate

	// Edge select, both gates enabling, and a guard until the synchroniser has settled
	always_comb begin
		next_prev  = pulse_in;
		next_prime = (prime == 2'd3) ? prime : prime + 2'd1;
		hit = (edge_fall_in ? (prev & ~pulse_in) : (~prev & pulse_in))
			& gate_hi_in & ~gate_lo_b_in & (prime == 2'd3);
		if (clear_in) begin
			next_count = '0;
		end else if (hit) begin
			next_count = count_out + W'(1);  // Rolls from all ones to zero
		end else begin
			next_count = count_out;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			prev      <= 1'b0;
			prime     <= 2'd0;
			count_out <= '0;
		end else begin
			prev      <= next_prev;
			prime     <= next_prime;
			count_out <= next_count;
		end
	end
endmodule

//--- tb/mfd_far_model.sv
// Far side of the block: port pins with pull-ups, pulse source, gates and a switch
`timescale 1ns/1ps
module mfd_far_model (
	// Clock
	input  wire logic       clk_in,
	// Device drive of the ports
	input  wire logic [7:0] port_a_out,
	input  wire logic [7:0] port_a_oe_out,
	input  wire logic [7:0] port_b_out,
	input  wire logic [7:0] port_b_oe_out,
	// Resolved pins and totalizer inputs
	output logic      [7:0] port_a_in,
	output logic      [7:0] port_b_in,
	output logic            tot_pulse_in,
	output logic            gate_hi_in,
	output logic            gate_lo_b_in,
	output logic            switch_pos_out
);
	logic [7:0] ext_a_val, ext_a_drv, ext_b_val, ext_b_drv;
	// Undriven gates: the high gate floats up, the low gate is grounded so it enables
	initial begin
		{ext_a_val, ext_a_drv, ext_b_val, ext_b_drv} = 32'h0000_0000;
		tot_pulse_in = 1'b0;
		gate_hi_in = 1'b1;
		gate_lo_b_in = 1'b0;
	end
	// Device wins where it drives; a bit nobody drives is pulled up to one
	assign port_a_in = (port_a_oe_out & port_a_out) | (~port_a_oe_out & ~(ext_a_drv & ~ext_a_val));
	assign port_b_in = (port_b_oe_out & port_b_out) | (~port_b_oe_out & ~(ext_b_drv & ~ext_b_val));
	// Two-way switch flips while its control bit is driven low
	assign switch_pos_out = port_b_oe_out[0] & ~port_b_out[0];

	task automatic set_ext(input logic [7:0] av, ad, bv, bd);
		@(posedge clk_in);
		ext_a_val <= av;
		ext_a_drv <= ad;
		ext_b_val <= bv;
		ext_b_drv <= bd;
	endtask
	task automatic set_gates(input logic hi, lo_b);
		@(posedge clk_in);
		gate_hi_in <= hi;
		gate_lo_b_in <= lo_b;
	endtask
	task automatic set_lvl(input logic lv);
		@(posedge clk_in);
		tot_pulse_in <= lv;
		repeat (6) @(posedge clk_in);
	endtask
	// Seven clocks high and low, well inside what the synchroniser can follow
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			set_lvl(1'b1);
			set_lvl(1'b0);
		end
	endtask
endmodule

//--- tb/mfd_top_asserts.sv
// Concurrent checks on the ports of the multifunction block
`timescale 1ns/1ps
`include "mfd_defs.svh"
module mfd_top_chk #(
	parameter int CNT_W = `MFD_CNT_W
) (
	// Clock and reset
	input wire logic             clk_in,
	input wire logic             rst_b_in,
	// Avalon-MM slave
	input wire logic [5:0]       avs_address_in,
	input wire logic             avs_read_in,
	input wire logic             avs_write_in,
	input wire logic [31:0]      avs_writedata_in,
	input wire logic [3:0]       avs_byteenable_in,
	input wire logic [31:0]      avs_readdata_out,
	input wire logic             avs_waitrequest_out,
	// Scan sequencer
	input wire logic             scan_trig_in,
	input wire logic             scan_done_out,
	input wire logic [15:0]      scan_port_out,
	input wire logic [CNT_W-1:0] scan_count_out,
	// Pins and codes
	input wire logic [7:0]       port_a_in,
	input wire logic [7:0]       port_b_in,
	input wire logic [7:0]       port_a_out,
	input wire logic [7:0]       port_b_out,
	input wire logic [7:0]       port_a_oe_out,
	input wire logic [15:0]      dac0_code_out,
	input wire logic [15:0]      dac1_code_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// A write lands at the edge where waitrequest is low
	logic wr_done;
	assign wr_done = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[1:0] == 2'b11;

	a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("waitrequest held longer than one cycle");
	a_rd_hold: assert property (!(avs_read_in && avs_waitrequest_out)
		|=> $stable(avs_readdata_out)) else $error("read data moved without a read");
	a_done_rise: assert property (scan_trig_in |=> scan_done_out)
		else $error("scan done missing");
	a_done_only: assert property (!scan_trig_in |=> !scan_done_out)
		else $error("scan done without trigger");
	a_scan_hold: assert property (!scan_trig_in |=> $stable(scan_count_out)
		&& $stable(scan_port_out)) else $error("scan data moved without trigger");
	a_scan_port: assert property ($stable({port_b_in, port_a_in})[*3] ##0 scan_trig_in
		|=> scan_port_out == $past({port_b_in, port_a_in})) else $error("scan port wrong");
	a_word_out: assert property (wr_done && avs_address_in == `MFD_OFS_PORT_OUT
		|=> {port_b_out, port_a_out} == $past(avs_writedata_in[15:0]))
		else $error("output word not driven");
	a_dac0_code: assert property (wr_done && avs_address_in == `MFD_OFS_DAC0
		|=> dac0_code_out == $past(avs_writedata_in[15:0])) else $error("dac0 code wrong");
	a_dac1_code: assert property (wr_done && avs_address_in == `MFD_OFS_DAC1
		|=> dac1_code_out == $past(avs_writedata_in[15:0])) else $error("dac1 code wrong");
	a_oe_group: assert property (port_a_oe_out == 8'h00 || port_a_oe_out == 8'hFF)
		else $error("port enable split");
endmodule

bind mfd_top mfd_top_chk #(.CNT_W(CNT_W)) u_chk (
	.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
	.avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .scan_trig_in,
	.scan_done_out, .scan_port_out, .scan_count_out, .port_a_in, .port_b_in, .port_a_out,
	.port_b_out, .port_a_oe_out, .dac0_code_out, .dac1_code_out
);

//--- tb/mfd_top_tb.sv
// Self-checking bench of the multifunction port, totalizer and code block
`timescale 1ns/1ps
`include "mfd_defs.svh"
module mfd_top_tb;
	localparam int CW = 4; // Short counter so the wrap comes quickly
	typedef struct packed {logic [5:0] a; logic [31:0] wd; logic [31:0] rd;} mfd_row_t;
	mfd_row_t rows [4] = '{'{`MFD_OFS_ALM_PAT, 32'hFFFF_1234, 32'h0000_1234},
		'{`MFD_OFS_DAC0, 32'h0000_8001, 32'h0000_8001},
		'{`MFD_OFS_DAC1, 32'h0000_7FFF, 32'h0000_7FFF},
		'{6'h3C, 32'h0000_BEEF, 32'h0000_0000}};
	logic            clk_in, rst_b_in, avs_read_in, avs_write_in, scan_trig_in;
	logic [5:0]      avs_address_in;
	logic [31:0]     avs_writedata_in, avs_readdata_out, q;
	logic [3:0]      avs_byteenable_in;
	logic            avs_waitrequest_out, scan_done_out, alarm_out, switch_pos_out;
	logic            tot_pulse_in, gate_hi_in, gate_lo_b_in;
	logic [15:0]     scan_port_out, dac0_code_out, dac1_code_out;
	logic [CW-1:0]   scan_count_out;
	logic [7:0]      port_a_in, port_a_out, port_a_oe_out, port_b_in, port_b_out, port_b_oe_out;
	int              err_count, comparisons;

	mfd_top #(.CNT_W(CW)) u_dut (.clk_in, .rst_b_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .scan_trig_in, .scan_done_out, .scan_port_out, .scan_count_out,
		.port_a_in, .port_a_out, .port_a_oe_out, .port_b_in, .port_b_out, .port_b_oe_out,
		.tot_pulse_in, .gate_hi_in, .gate_lo_b_in, .alarm_out, .dac0_code_out, .dac1_code_out);
	mfd_far_model u_far (.clk_in, .port_a_out, .port_a_oe_out, .port_b_out, .port_b_oe_out,
		.port_a_in, .port_b_in, .tot_pulse_in, .gate_hi_in, .gate_lo_b_in, .switch_pos_out);

	// 40 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic complete_run();
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk_reg(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_pin(input string nm, input logic [15:0] e, g);
		chk_reg(nm, {16'h0000, e}, {16'h0000, g});
	endtask
	// Request holds until waitrequest is sampled low at a rising edge; data taken there too
	// No wait count is assumed: only the watchdog ends a hung access
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk_reg(nm, e, q);
	endtask
	task automatic scan(input logic [15:0] ep, input logic [CW-1:0] ec);
		@(posedge clk_in);
		scan_trig_in <= 1'b1;
		@(posedge clk_in);
		scan_trig_in <= 1'b0;
		@(negedge clk_in);
		chk_pin("scan_done", 16'h0001, {15'h0000, scan_done_out});
		chk_pin("scan_port", ep, scan_port_out);
		chk_pin("scan_count", 16'(ec), 16'(scan_count_out));
	endtask
	// Watchdog well beyond the few hundred cycles of the sequence
	initial begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		{rst_b_in, avs_read_in, avs_write_in, scan_trig_in} = 4'h0;
		{avs_address_in, avs_writedata_in, q} = '0;
		avs_byteenable_in = 4'hF;
		err_count = 0;
		comparisons = 0;
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		@(negedge clk_in);
		chk_pin("port_out", 16'hFFFF, {port_b_out, port_a_out});
		chk_pin("port_oe", 16'h0000, {port_b_oe_out, port_a_oe_out});
		chk_pin("alarm", 16'h0000, {15'h0000, alarm_out});
		rd_chk("alm_mask", `MFD_OFS_ALM_MASK, 32'h0000_FFFF);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].wd);
			rd_chk("row", rows[i].a, rows[i].rd);
		end
		// Only the upper byte lane is enabled, so the low byte must survive
		avs_byteenable_in <= 4'h2;
		bus(1'b1, `MFD_OFS_ALM_PAT, 32'h0000_AB99);
		avs_byteenable_in <= 4'hF;
		rd_chk("alm_pat_be", `MFD_OFS_ALM_PAT, 32'h0000_AB34);
		@(negedge clk_in);
		chk_pin("dac0", 16'h8001, dac0_code_out);
		chk_pin("dac1", 16'h7FFF, dac1_code_out);
		// Open bits read one, grounded bits read zero
		u_far.set_ext(8'h3C, 8'hFF, 8'h00, 8'h0F);
		repeat (4) @(posedge clk_in);
		rd_chk("port_in", `MFD_OFS_PORT_IN, 32'h0000_F03C);
		// Totalizer: clear, count, both gates, wrap, falling edge
		bus(1'b1, `MFD_OFS_CTRL, 32'h0000_0002);
		bus(1'b1, `MFD_OFS_CTRL, 32'h0000_0000);
		u_far.pulses(5);
		rd_chk("count", `MFD_OFS_COUNT, 32'd5);
		u_far.set_gates(1'b0, 1'b0);
		u_far.pulses(3);
		rd_chk("count_gate_hi", `MFD_OFS_COUNT, 32'd5);
		u_far.set_gates(1'b1, 1'b1);
		u_far.pulses(3);
		rd_chk("count_gate_lo", `MFD_OFS_COUNT, 32'd5);
		u_far.set_gates(1'b1, 1'b0);
		u_far.pulses(13);
		scan(16'hF03C, CW'(18 % (1 << CW)));
		rd_chk("count_wrap", `MFD_OFS_COUNT, 32'(18 % (1 << CW)));
		bus(1'b1, `MFD_OFS_CTRL, 32'h0000_0001);
		u_far.set_lvl(1'b1);
		rd_chk("count_rise", `MFD_OFS_COUNT, 32'(18 % (1 << CW)));
		u_far.set_lvl(1'b0);
		rd_chk("count_fall", `MFD_OFS_COUNT, 32'(19 % (1 << CW)));
		// Alarm on match, outside any scan, then on change
		bus(1'b1, `MFD_OFS_ALM_MASK, 32'h0000_00FF);
		bus(1'b1, `MFD_OFS_ALM_PAT, 32'h0000_0055);
		bus(1'b1, `MFD_OFS_CTRL, 32'h0000_0020);
		u_far.set_ext(8'h55, 8'hFF, 8'h00, 8'h0F);
		repeat (4) @(posedge clk_in);
		rd_chk("status", `MFD_OFS_STATUS, 32'h0000_0005);
		u_far.set_ext(8'h3C, 8'hFF, 8'h00, 8'h0F);
		repeat (4) @(posedge clk_in);
		bus(1'b1, `MFD_OFS_STATUS, 32'h0000_0007);
		@(negedge clk_in);
		chk_pin("alarm_clr", 16'h0000, {15'h0000, alarm_out});
		bus(1'b1, `MFD_OFS_CTRL, 32'h0000_0030);
		u_far.set_ext(8'h3D, 8'hFF, 8'h00, 8'h0F);
		repeat (4) @(posedge clk_in);
		chk_pin("alarm_chg", 16'h0001, {15'h0000, alarm_out});
		// One 16-bit word across both ports
		u_far.set_ext(8'h00, 8'h00, 8'h00, 8'h00);
		bus(1'b1, `MFD_OFS_CTRL, 32'h0000_000C);
		bus(1'b1, `MFD_OFS_PORT_OUT, 32'h0000_5AA5);
		@(negedge clk_in);
		chk_pin("port_word", 16'h5AA5, {port_b_out, port_a_out});
		chk_pin("port_oe", 16'hFFFF, {port_b_oe_out, port_a_oe_out});
		chk_pin("switch", 16'h0001, {15'h0000, switch_pos_out});
		repeat (4) @(posedge clk_in);
		rd_chk("port_pins", `MFD_OFS_PORT_IN, 32'h0000_5AA5);
		complete_run();
	end
endmodule
